// File: ehin_node.sv
// fault frame, heartbeat and identity objects behind the service-data server
`timescale 1ns/1ns
`include "ehin_defines.svh"
// Behaviour
// - fault frame identifier resets to 128 plus station number, valid; master may rewrite it
// - identifier bit 31 set means no fault frames are sent at all
// - identifier bits 0-10 hold the id; bits 11-30 must be zero, 29-bit ids refused
// - fault frames use the configured identifier and carry exactly eight bytes
// - a fault acknowledgement sends one fault frame with all eight bytes zero
// - bytes: error code low/high, error register, three zeros, internal code low/high
// - three consumer slots at sub-indexes 1-3; sub-index 0 reads 3, read-only
// - a consumer entry of zero disables that slot; it never times out
// - consumer entry: bits 0-15 interval in ms, 16-23 node, 24-31 unused
// - a heartbeat gap longer than the interval triggers the abort-connection reaction
// - own heartbeat sent every producer period in ms; period resets to zero
// - a producer period of zero sends no heartbeat
// - identity object read-only; sub 0 reads 4; subs 1-4 four 32-bit words
// - requests on 1536 plus station number, answers on 1408 plus station number
// - heartbeat loss: 0 operational to pre-operational, 1 no change, 2 stopped
module ehin_node #(
   parameter int          MS_CYCLES       = `EHIN_MS_CYCLES,
   parameter logic [31:0] MAKER_ID        = 32'h0000_0A5A, // arbitrary value
   parameter logic [31:0] TYPE_CODE       = 32'h0000_0001,
   parameter logic [31:0] SYSTEM_REVISION = 32'h0000_0001,
   parameter logic [31:0] UNIT_SERIAL     = 32'h0000_0001
)(
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   input  wire logic [6:0]              station_number,
   input  wire ehin_pkg::ehin_frame_type rx_frame,
   input  wire logic                    tx_ready,
   output ehin_pkg::ehin_frame_type     tx_frame,
   input  wire logic                    fault_new,
   input  wire logic                    fault_ack,
   input  wire ehin_pkg::ehin_fault_type fault_info,
   input  wire logic [6:0]              network_management_state,
   input  wire logic [15:0]             abort_option_code,
   input  wire logic [7:0]              error_behaviour,
   output logic                         hb_lost,
   output logic [2:0]                   hb_lost_slots,
   output logic [15:0]                  abort_reaction,
   output logic                         nm_to_preop,
   output logic                         nm_to_stopped
);
   import ehin_pkg::*;

   // --------------------
   // state
   // --------------------
   logic [31:0]       fault_id_q, fault_id_d;
   ehin_consumer_type cons_q, cons_d;
   logic [15:0]       prod_q, prod_d;
   ehin_fault_type    snap_q, snap_d;
   logic              pend_fault_q, pend_fault_d;
   logic              pend_ack_q, pend_ack_d;
   logic              pend_hb_q, pend_hb_d;
   logic              pend_sdo_q, pend_sdo_d;
   logic [7:0][7:0]   sdo_ans_q, sdo_ans_d;
   ehin_frame_type    tx_q, tx_d;
   logic              lost_q, lost_d;
   logic [2:0]        slots_q, slots_d;
   logic [15:0]       react_q, react_d;
   logic              preop_q, preop_d;
   logic              stop_q, stop_d;

   // --------------------
   // request decode, timer and arbitration scratch
   // --------------------
   logic              ms_tick;
   logic              hb_due;
   logic [2:0]        timeout;
   logic              req_hit;
   logic [7:0]        cmd;
   logic [15:0]       idx;
   logic [7:0]        sub;
   logic [31:0]       wval;
   logic [31:0]       rval;
   logic [7:0]        rcs;
   logic [31:0]       abort_code;
   logic              is_abort;
   logic              load;
   logic              fault_ok;

   ehin_hb_producer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_producer (
      .core_clk (core_clk),
      .srst     (srst),
      .period   (prod_q),
      .ms_tick  (ms_tick),
      .hb_due   (hb_due)
   );

   ehin_hb_consumer u_consumer (
      .core_clk (core_clk),
      .srst     (srst),
      .ms_tick  (ms_tick),
      .entries  (cons_q),
      .rx_frame (rx_frame),
      .timeout  (timeout)
   );

   // --------------------
   // service-data server
   // --------------------
   always_comb begin
      // a second request while an answer waits is dropped, not queued
      req_hit    = rx_frame.valid && rx_frame.dlc == `EHIN_FRAME_DLC && !pend_sdo_q &&
                   rx_frame.id == 11'(`EHIN_SDO_RX_BASE + {4'h0, station_number});
      cmd        = rx_frame.data[0];
      idx        = {rx_frame.data[2], rx_frame.data[1]};
      sub        = rx_frame.data[3];
      wval       = {rx_frame.data[7], rx_frame.data[6], rx_frame.data[5], rx_frame.data[4]};
      rval       = '0;
      rcs        = `EHIN_ANS_WRITE;
      abort_code = '0;
      is_abort   = 1'b0;
      fault_id_d = fault_id_q;
      cons_d     = cons_q;
      prod_d     = prod_q;
      if (cmd[7:5] == `EHIN_CS_UPLOAD) begin
         rcs = `EHIN_ANS_READ4;
         unique case (idx)
            `EHIN_IDX_FAULT_ID: begin
               if (sub == 8'h00) rval = fault_id_q;
               else abort_code = `EHIN_ABORT_NO_SUB;
            end
            `EHIN_IDX_HB_CONSUMER: begin
               if (sub == 8'h00) begin
                  rval = {24'h00_0000, `EHIN_HB_CONSUMER_COUNT};
                  rcs  = `EHIN_ANS_READ1;
               end else if (sub <= `EHIN_HB_CONSUMER_COUNT) begin
                  rval = {8'h00, cons_q[sub[1:0] - 2'd1]};
               end else abort_code = `EHIN_ABORT_NO_SUB;
            end
            `EHIN_IDX_HB_PRODUCER: begin
               if (sub == 8'h00) begin
                  rval = {16'h0000, prod_q};
                  rcs  = `EHIN_ANS_READ2;
               end else abort_code = `EHIN_ABORT_NO_SUB;
            end
            `EHIN_IDX_IDENTITY: begin
               unique case (sub)
                  8'h00: begin
                     rval = {24'h00_0000, `EHIN_IDENTITY_COUNT};
                     rcs  = `EHIN_ANS_READ1;
                  end
                  8'h01: rval = MAKER_ID;
                  8'h02: rval = TYPE_CODE;
                  8'h03: rval = SYSTEM_REVISION;
                  8'h04: rval = UNIT_SERIAL;
                  default: abort_code = `EHIN_ABORT_NO_SUB;
               endcase
            end
            default: abort_code = `EHIN_ABORT_NO_OBJECT;
         endcase
      end else if (cmd[7:5] == `EHIN_CS_DOWNLOAD && cmd[1]) begin
         unique case (idx)
            `EHIN_IDX_FAULT_ID: begin
               if (sub != 8'h00) abort_code = `EHIN_ABORT_NO_SUB;
               else if (wval[`EHIN_FAULT_ZERO_HI:`EHIN_FAULT_ZERO_LO] != '0) abort_code = `EHIN_ABORT_RANGE;
               else if (req_hit) fault_id_d = wval;
            end
            `EHIN_IDX_HB_CONSUMER: begin
               if (sub == 8'h00) abort_code = `EHIN_ABORT_READ_ONLY;
               else if (sub <= `EHIN_HB_CONSUMER_COUNT) begin
                  if (req_hit) cons_d[sub[1:0] - 2'd1] = wval[23:0];
               end else abort_code = `EHIN_ABORT_NO_SUB;
            end
            `EHIN_IDX_HB_PRODUCER: begin
               if (sub != 8'h00) abort_code = `EHIN_ABORT_NO_SUB;
               else if (req_hit) prod_d = wval[15:0];
            end
            `EHIN_IDX_IDENTITY: begin
               if (sub <= `EHIN_IDENTITY_COUNT) abort_code = `EHIN_ABORT_READ_ONLY;
               else abort_code = `EHIN_ABORT_NO_SUB;
            end
            default: abort_code = `EHIN_ABORT_NO_OBJECT;
         endcase
      end else begin
         abort_code = `EHIN_ABORT_CMD; // segmented transfers are not served here
      end
      is_abort = abort_code != '0;
      if (is_abort) begin
         rcs  = `EHIN_ANS_ABORT;
         rval = abort_code;
      end
      sdo_ans_d = sdo_ans_q;
      if (req_hit) begin
         sdo_ans_d = {rval[31:24], rval[23:16], rval[15:8], rval[7:0], sub, idx[15:8], idx[7:0], rcs};
      end
   end

   // --------------------
   // pending frames and transmit arbitration
   // --------------------
   always_comb begin
      fault_ok = !fault_id_q[`EHIN_FAULT_INVALID_BIT];
      load     = !tx_q.valid || tx_ready;
      tx_d     = tx_q;
      if (tx_ready) tx_d.valid = 1'b0;
      snap_d = snap_q;
      if (fault_new) snap_d = fault_info;
      pend_fault_d = pend_fault_q;
      pend_ack_d   = pend_ack_q;
      pend_hb_d    = pend_hb_q;
      pend_sdo_d   = pend_sdo_q;
      if (load) begin
         if (pend_fault_q && fault_ok) begin
            tx_d.valid = 1'b1;
            tx_d.id    = fault_id_q[10:0];
            tx_d.dlc   = `EHIN_FRAME_DLC;
            tx_d.data  = {snap_q.internal[15:8], snap_q.internal[7:0], 8'h00, 8'h00, 8'h00,
                          snap_q.register, snap_q.code[15:8], snap_q.code[7:0]};
            pend_fault_d = 1'b0;
         end else if (pend_ack_q && fault_ok) begin
            tx_d.valid = 1'b1;
            tx_d.id    = fault_id_q[10:0];
            tx_d.dlc   = `EHIN_FRAME_DLC;
            tx_d.data  = '0;
            pend_ack_d = 1'b0;
         end else if (pend_sdo_q) begin
            tx_d.valid = 1'b1;
            tx_d.id    = 11'(`EHIN_SDO_TX_BASE + {4'h0, station_number});
            tx_d.dlc   = `EHIN_FRAME_DLC;
            tx_d.data  = sdo_ans_q;
            pend_sdo_d = 1'b0;
         end else if (pend_hb_q) begin
            tx_d.valid = 1'b1;
            tx_d.id    = 11'(`EHIN_HB_BASE + {4'h0, station_number});
            tx_d.dlc   = `EHIN_HB_DLC;
            tx_d.data  = {56'h0, 1'b0, network_management_state};
            pend_hb_d  = 1'b0;
         end
      end
      // sets win over the clears above; an invalid identifier drops fault frames
      if (fault_new) pend_fault_d = 1'b1;
      if (fault_ack) pend_ack_d = 1'b1;
      if (!fault_ok) begin
         pend_fault_d = 1'b0;
         pend_ack_d   = 1'b0;
      end
      if (hb_due) pend_hb_d = 1'b1;
      if (req_hit) pend_sdo_d = 1'b1;
   end

   // --------------------
   // heartbeat loss reaction
   // --------------------
   always_comb begin
      lost_d  = |timeout;
      slots_d = timeout;
      react_d = react_q;
      preop_d = 1'b0;
      stop_d  = 1'b0;
      if (|timeout) begin
         react_d = abort_option_code;
         unique case (error_behaviour)
            `EHIN_BEHAVE_PREOP:   preop_d = network_management_state == `EHIN_NM_OPERATIONAL;
            `EHIN_BEHAVE_KEEP:    preop_d = 1'b0;
            `EHIN_BEHAVE_STOPPED: stop_d = 1'b1;
            default:              preop_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fault_id_q   <= {21'h00_0000, 11'(`EHIN_FAULT_ID_BASE + {4'h0, station_number})};
         cons_q       <= '0;
         prod_q       <= `EHIN_HB_PROD_RESET;
         snap_q       <= '0;
         pend_fault_q <= 1'b0;
         pend_ack_q   <= 1'b0;
         pend_hb_q    <= 1'b0;
         pend_sdo_q   <= 1'b0;
         sdo_ans_q    <= '0;
         tx_q         <= '0;
         lost_q       <= 1'b0;
         slots_q      <= '0;
         react_q      <= '0;
         preop_q      <= 1'b0;
         stop_q       <= 1'b0;
      end else begin
         fault_id_q   <= fault_id_d;
         cons_q       <= cons_d;
         prod_q       <= prod_d;
         snap_q       <= snap_d;
         pend_fault_q <= pend_fault_d;
         pend_ack_q   <= pend_ack_d;
         pend_hb_q    <= pend_hb_d;
         pend_sdo_q   <= pend_sdo_d;
         sdo_ans_q    <= sdo_ans_d;
         tx_q         <= tx_d;
         lost_q       <= lost_d;
         slots_q      <= slots_d;
         react_q      <= react_d;
         preop_q      <= preop_d;
         stop_q       <= stop_d;
      end
   end

   assign tx_frame       = tx_q;
   assign hb_lost        = lost_q;
   assign hb_lost_slots  = slots_q;
   assign abort_reaction = react_q;
   assign nm_to_preop    = preop_q;
   assign nm_to_stopped  = stop_q;

endmodule

// File: ehin_defines.svh
// constants for the fault frame, heartbeat and identity node
`ifndef EHIN_DEFINES_SVH
`define EHIN_DEFINES_SVH

// --------------------
// object indexes and sub-index counts
// --------------------
`define EHIN_IDX_FAULT_ID      16'h1014
`define EHIN_IDX_HB_CONSUMER   16'h1016
`define EHIN_IDX_HB_PRODUCER   16'h1017
`define EHIN_IDX_IDENTITY      16'h1018
`define EHIN_HB_CONSUMER_COUNT 8'h03
`define EHIN_IDENTITY_COUNT    8'h04

// --------------------
// identifiers and field positions
// --------------------
`define EHIN_FAULT_ID_BASE     11'h080
`define EHIN_SDO_RX_BASE       11'h600
`define EHIN_SDO_TX_BASE       11'h580
`define EHIN_HB_BASE           11'h700
`define EHIN_FAULT_INVALID_BIT 31
`define EHIN_FAULT_FORMAT_BIT  29
`define EHIN_FAULT_ZERO_HI     30
`define EHIN_FAULT_ZERO_LO     11
`define EHIN_HB_PROD_RESET     16'h0000
`define EHIN_FRAME_DLC         4'h8
`define EHIN_HB_DLC            4'h1

// --------------------
// service-data command and answer codes
// --------------------
`define EHIN_CS_DOWNLOAD       3'b001
`define EHIN_CS_UPLOAD         3'b010
`define EHIN_ANS_WRITE         8'h60
`define EHIN_ANS_READ4         8'h43
`define EHIN_ANS_READ2         8'h4B
`define EHIN_ANS_READ1         8'h4F
`define EHIN_ANS_ABORT         8'h80
`define EHIN_ABORT_CMD         32'h0504_0001
`define EHIN_ABORT_READ_ONLY   32'h0601_0002
`define EHIN_ABORT_NO_OBJECT   32'h0602_0000
`define EHIN_ABORT_NO_SUB      32'h0609_0011
`define EHIN_ABORT_RANGE       32'h0609_0030

// --------------------
// network management and error behaviour
// --------------------
`define EHIN_NM_OPERATIONAL    7'h05
`define EHIN_BEHAVE_PREOP      8'h00
`define EHIN_BEHAVE_KEEP       8'h01
`define EHIN_BEHAVE_STOPPED    8'h02

// --------------------
// timing
// --------------------
`define EHIN_CLK_PERIOD_NS     4
`define EHIN_MS_NS             1000000
`define EHIN_MS_CYCLES         (`EHIN_MS_NS / `EHIN_CLK_PERIOD_NS)

`endif

// File: ehin_pkg.sv
// types shared by the fault frame, heartbeat and identity node
package ehin_pkg;

   // ---------------------------------------------------------------
   // frame carried to and from the bus controller
   // ---------------------------------------------------------------
   typedef struct packed {
      logic            valid;
      logic [10:0]     id;
      logic [3:0]      dlc;
      logic [7:0][7:0] data;
   } ehin_frame_type;

   // ---------------------------------------------------------------
   // fault snapshot
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] code;
      logic [7:0]  register;
      logic [15:0] internal;
   } ehin_fault_type;

   typedef logic [2:0][23:0] ehin_consumer_type;

endpackage

// File: ehin_hb_producer.sv
// millisecond tick and own heartbeat period timer
`timescale 1ns/1ns
`include "ehin_defines.svh"
module ehin_hb_producer #(
   parameter int MS_CYCLES = `EHIN_MS_CYCLES
)(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [15:0] period,
   output logic             ms_tick,
   output logic             hb_due
);
   import ehin_pkg::*;

   localparam int TW = $clog2(MS_CYCLES + 1);

   logic [TW-1:0] tick_cnt_q;
   logic [TW-1:0] tick_cnt_d;
   logic [15:0]   ms_cnt_q;
   logic [15:0]   ms_cnt_d;
   logic          due_q;
   logic          due_d;
   logic          tick_q;
   logic          tick_d;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      tick_d     = 1'b0;
      tick_cnt_d = tick_cnt_q + TW'(1);
      if (tick_cnt_q == TW'(MS_CYCLES - 1)) begin
         tick_cnt_d = '0;
         tick_d     = 1'b1;
      end
      due_d    = 1'b0;
      ms_cnt_d = ms_cnt_q;
      if (period == 16'h0000) begin
         ms_cnt_d = '0;
      end else if (tick_q) begin
         // >= catches a period lowered below the running count
         if (ms_cnt_q + 16'h0001 >= period) begin
            ms_cnt_d = '0;
            due_d    = 1'b1;
         end else begin
            ms_cnt_d = ms_cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
         ms_cnt_q   <= '0;
         due_q      <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q     <= tick_d;
         ms_cnt_q   <= ms_cnt_d;
         due_q      <= due_d;
      end
   end

   assign ms_tick = tick_q;
   assign hb_due  = due_q;

endmodule

// File: ehin_hb_consumer.sv
// monitoring of three remote heartbeat producers
`timescale 1ns/1ns
`include "ehin_defines.svh"
module ehin_hb_consumer (
   input  wire logic                       core_clk,
   input  wire logic                       srst,
   input  wire logic                       ms_tick,
   input  wire ehin_pkg::ehin_consumer_type entries,
   input  wire ehin_pkg::ehin_frame_type    rx_frame,
   output logic [2:0]                      timeout
);
   import ehin_pkg::*;

   genvar s;
   generate
      for (s = 0; s < 3; s++) begin : g_slot
         logic        armed_q;
         logic        armed_d;
         logic [15:0] cnt_q;
         logic [15:0] cnt_d;
         logic        to_q;
         logic        to_d;
         logic        seen;

         // ---------------------------------------------------------------
         // per slot watchdog
         // ---------------------------------------------------------------
         always_comb begin
            seen    = rx_frame.valid && rx_frame.dlc != 4'h0 &&
                      rx_frame.id == 11'(`EHIN_HB_BASE + {3'b000, entries[s][23:16]});
            armed_d = armed_q;
            cnt_d   = cnt_q;
            to_d    = 1'b0;
            if (entries[s][15:0] == 16'h0000) begin
               armed_d = 1'b0;
               cnt_d   = '0;
            end else if (seen) begin
               armed_d = 1'b1; // monitoring starts at first heartbeat
               cnt_d   = '0;
            end else if (armed_q && ms_tick) begin
               if (cnt_q >= entries[s][15:0]) begin
                  to_d    = 1'b1;
                  armed_d = 1'b0; // one event per loss, not a flood
                  cnt_d   = '0;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
         end

         always_ff @(posedge core_clk) begin
            if (srst) begin
               armed_q <= 1'b0;
               cnt_q   <= '0;
               to_q    <= 1'b0;
            end else begin
               armed_q <= armed_d;
               cnt_q   <= cnt_d;
               to_q    <= to_d;
            end
         end

         assign timeout[s] = to_q;
      end
   endgenerate

endmodule

// File: ehin_node_asserts.sv
// assertions on the frame and reaction ports of the node
`timescale 1ns/1ns
module ehin_node_asserts
   import ehin_pkg::*;
(
   input wire logic                     core_clk,
   input wire logic                     srst,
   input wire logic [6:0]               station_number,
   input wire ehin_pkg::ehin_frame_type rx_frame,
   input wire logic                     tx_ready,
   input wire ehin_pkg::ehin_frame_type tx_frame,
   input wire logic [6:0]               network_management_state,
   input wire logic [15:0]              abort_option_code,
   input wire logic [7:0]               error_behaviour,
   input wire logic                     hb_lost,
   input wire logic [2:0]               hb_lost_slots,
   input wire logic [15:0]              abort_reaction,
   input wire logic                     nm_to_preop,
   input wire logic                     nm_to_stopped
);
   wire logic [10:0] sdo_rx = 11'h600 + 11'(station_number);
   wire logic [10:0] sdo_tx = 11'h580 + 11'(station_number);
   wire logic [10:0] hb_id  = 11'h700 + 11'(station_number);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   tx_hold_a: assert property (tx_frame.valid && !tx_ready |=> $stable(tx_frame))
      else $error("tx frame changed before accept");
   frame_len_a: assert property (tx_frame.valid && tx_frame.id != hb_id |-> tx_frame.dlc == 4'h8)
      else $error("frame length not eight bytes");
   fault_pad_a: assert property (
      tx_frame.valid && tx_frame.id != sdo_tx && tx_frame.id != hb_id |-> tx_frame.data[5:3] == 24'h00_0000)
      else $error("fault frame padding not zero");
   hb_frame_a: assert property (
      tx_frame.valid && tx_frame.id == hb_id |->
      tx_frame.dlc == 4'h1 && tx_frame.data[0] == {1'b0, network_management_state})
      else $error("heartbeat frame malformed");
   sdo_answer_a: assert property (
      rx_frame.valid && rx_frame.id == sdo_rx && rx_frame.dlc == 4'h8 && !tx_frame.valid |->
      ##[2:40] tx_frame.valid && tx_frame.id == sdo_tx)
      else $error("no answer on the service-data reply id");
   lost_any_a: assert property (hb_lost == (hb_lost_slots != 3'b000))
      else $error("loss pulse and slot flags disagree");
   react_take_a: assert property (hb_lost |-> ##[0:1] abort_reaction == abort_option_code)
      else $error("reaction code not captured");
   react_hold_a: assert property ($changed(abort_reaction) |-> hb_lost || $past(hb_lost))
      else $error("reaction code changed without loss");
   preop_a: assert property (
      hb_lost && $past(error_behaviour) == 8'h00 && $past(network_management_state) == 7'h05 |-> nm_to_preop)
      else $error("no move to pre-operational");
   stop_a: assert property (nm_to_stopped |-> $past(error_behaviour) == 8'h02)
      else $error("stopped without matching behaviour");
endmodule
bind ehin_node ehin_node_asserts u_chk (.core_clk, .srst, .station_number, .rx_frame, .tx_ready, .tx_frame,
   .network_management_state, .abort_option_code, .error_behaviour, .hb_lost, .hb_lost_slots,
   .abort_reaction, .nm_to_preop, .nm_to_stopped);

// File: ehin_bus_model.sv
// bus controller model: takes node frames promptly or after a stall
`timescale 1ns/1ns
module ehin_bus_model
   import ehin_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   input  wire logic                     slow,
   input  wire ehin_pkg::ehin_frame_type tx_frame,
   output logic                          tx_ready,
   output ehin_pkg::ehin_frame_type      last,
   output int                            count
);
   logic [1:0] wait_q;
   // slow mode holds ready low two cycles, as a busy bus would
   assign tx_ready = tx_frame.valid && (!slow || wait_q == 2'h2);
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wait_q <= 2'h0;
         count  <= 0;
      end else if (tx_ready) begin
         wait_q <= 2'h0;
         last   <= tx_frame;
         count  <= count + 1;
      end else if (tx_frame.valid) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule

// File: tb_ehin_node.sv
// self-checking bench for the fault frame, heartbeat and identity node
`timescale 1ns/1ns
module tb_ehin_node;
   import ehin_pkg::*;
   localparam logic [6:0]  STN = 7'h0A;
   // identity words, values arbitrary
   localparam logic [31:0] IDS [4] = '{32'h0000_0C3C, 32'h0000_0321, 32'h0000_0002, 32'h0001_2345};
   logic           core_clk = 1'b0, srst = 1'b1, slow = 1'b0, fault_new = 1'b0, fault_ack = 1'b0;
   logic           tx_ready, hb_lost, nm_to_preop, nm_to_stopped;
   logic [6:0]     network_management_state = 7'h05;
   logic [7:0]     error_behaviour = 8'h00;
   logic [15:0]    abort_option_code = 16'h0003, abort_reaction;
   logic [2:0]     hb_lost_slots;
   ehin_frame_type rx_frame = '0, tx_frame, last;
   ehin_fault_type fault_info = 40'h12_3456_789A;
   int             mismatches = 0, check_count = 0, count, cycles = 0;
   always #2 core_clk = ~core_clk;
   ehin_node #(.MS_CYCLES(10), .MAKER_ID(IDS[0]), .TYPE_CODE(IDS[1]), .SYSTEM_REVISION(IDS[2]),
      .UNIT_SERIAL(IDS[3])) DUT (.core_clk, .srst, .station_number(STN), .rx_frame, .tx_ready, .tx_frame,
      .fault_new, .fault_ack, .fault_info, .network_management_state, .abort_option_code, .error_behaviour,
      .hb_lost, .hb_lost_slots, .abort_reaction, .nm_to_preop, .nm_to_stopped);
   ehin_bus_model bus (.core_clk, .srst, .slow, .tx_frame, .tx_ready, .last, .count);
   // --------------------
   // tasks
   // --------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask
   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
      @(negedge core_clk);
      rx_frame = '{1'b1, id, dlc, d};
      @(negedge core_clk);
      rx_frame.valid = 1'b0;
   endtask
   // bounded wait for the next accepted frame
   task automatic get(output ehin_frame_type f);
      int n;
      n = count;
      repeat (200) if (count == n) @(negedge core_clk);
      chk("frame arrived", count != n, 1'b1);
      f = last;
   endtask
   task automatic sdo(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] val, input logic [7:0] ecmd, input logic [31:0] eval);
      ehin_frame_type f;
      send(11'h600 + 11'(STN), 4'h8, {val, sub, idx, cmd});
      get(f);
      chk("answer id", f.id, 11'h580 + 11'(STN));
      chk("answer cmd", f.data[0], ecmd);
      chk("answer value", f.data[7:4], eval);
   endtask
   // --------------------
   // hang guard, a few hundred cycles expected
   // --------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_of_test;
      end
   end
   // --------------------
   // scenarios
   // --------------------
   initial begin
      ehin_frame_type f;
      int t0;
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      sdo(8'h40, 16'h1014, 8'h00, 0, 8'h43, 32'h0000_0080 + STN);
      sdo(8'h40, 16'h1017, 8'h00, 0, 8'h4B, 0);
      sdo(8'h40, 16'h1016, 8'h00, 0, 8'h4F, 3);
      sdo(8'h23, 16'h1016, 8'h00, 0, 8'h80, 32'h0601_0002);
      sdo(8'h40, 16'h1018, 8'h00, 0, 8'h4F, 4);
      foreach (IDS[i]) sdo(8'h40, 16'h1018, 8'(i + 1), 0, 8'h43, IDS[i]);
      sdo(8'h23, 16'h1018, 8'h02, 0, 8'h80, 32'h0601_0002);
      sdo(8'h23, 16'h1014, 8'h00, 32'h2000_0081, 8'h80, 32'h0609_0030);
      pulse(fault_new);
      fault_info = '0;
      get(f);
      chk("fault id", f.id, 11'h080 + 11'(STN));
      chk("fault data", f.data, 64'h789A_0000_0056_1234);
      pulse(fault_ack);
      get(f);
      chk("ack data", f.data, 0);
      sdo(8'h23, 16'h1014, 8'h00, 32'h8000_0123, 8'h60, 0);
      t0 = count;
      pulse(fault_new);
      repeat (30) @(negedge core_clk);
      chk("no fault frame", count, t0);
      slow = 1'b1;
      sdo(8'h23, 16'h1014, 8'h00, 32'h0000_0123, 8'h60, 0);
      pulse(fault_new);
      get(f);
      chk("new fault id", f.id, 11'h123);
      slow = 1'b0;
      sdo(8'h2B, 16'h1017, 8'h00, 2, 8'h60, 0);
      get(f);
      t0 = cycles;
      get(f);
      chk("heartbeat id", f.id, 11'h700 + 11'(STN));
      chk("heartbeat gap", cycles - t0, 20);
      sdo(8'h2B, 16'h1017, 8'h00, 0, 8'h60, 0);
      t0 = count;
      repeat (60) @(negedge core_clk);
      chk("no heartbeat", count, t0);
      sdo(8'h23, 16'h1016, 8'h01, 32'h0022_0003, 8'h60, 0);
      sdo(8'h40, 16'h1016, 8'h01, 0, 8'h43, 32'h0022_0003);
      for (int b = 0; b < 3; b++) begin
         error_behaviour = 8'(b);
         send(11'h722, 4'h1, 64'h05);
         t0 = cycles;
         repeat (80) if (!hb_lost) @(negedge core_clk);
         chk("loss slots", hb_lost_slots, 3'b001);
         chk("loss time", (cycles - t0) inside {[31:44]}, 1'b1);
         chk("to preop", nm_to_preop, b == 0);
         chk("to stopped", nm_to_stopped, b == 2);
      end
      chk("reaction", abort_reaction, 16'h0003);
      end_of_test;
   end
endmodule
